// >>> hdl/line_xcvr_pkg.sv
// Purpose: constants for the sensor line transceiver control block
// Assumes: 50 MHz clk, classic wishbone register access
// Notes: operation list below
// Operation
// - push_pull_select picks push-pull, else open-drain with low/high-side polarity
// - driver enabled by enable pin or enable bit, minus overrides
// - line output is NAND of transmit inputs; receive output inverts line
// - receive_output_disable holds receive output high; receiver stays powered
// - one filter bit picks 500kHz or 1MHz for both receivers
// - overcurrent held longer than 160us records a line fault
// - open-drain driver off with line between thresholds is a line fault
// - line fault sets flag, event, interrupt; driver off 240us after start
// - after short shutdown retry 350us every 26ms while short persists
// - driver floats until all supplies are good; undervoltage output floats until logic supplies are good
// - driver off whenever main, logic or logic-level supply is low
// - main supply low sets flag, event, indicator, interrupt; always monitored
// - registers kept with logic supply; no access or irq on logic undervoltage
// - low rail undervoltage sets event and irq; indicator only when enabled
// - indicator follows condition; events and irq held until status read
// - in wake-up, low transmit input drives line opposite previous sensed level
// - wake_soft_enable acts exactly like wake_pin_enable
// - above 115C hot flag and event, irq; read clears event; flag clears below 95C
// - above 150C driver and sinks off, registers alive; restore after cooling
// - status read clears events; a persisting line fault sets its event again
// - four 8-bit registers at a 2-bit register address
package line_xcvr_pkg;
   // ********************************
   // register map (index * 4 = byte address)
   // ********************************
   localparam logic [1:0] REG_STATUS = 2'h0;
   localparam logic [1:0] REG_LINE_CFG = 2'h1;
   localparam logic [1:0] REG_AUX_CFG = 2'h2;
   localparam logic [1:0] REG_MODE = 2'h3;
   localparam logic [7:0] LINE_CFG_RESET = 8'h00;
   localparam logic [1:0] AUX_CFG_RESET = 2'h0;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // line_config_register fields
   localparam int CFG_SINK = 0;
   localparam int CFG_RECEIVE_OUTPUT_DISABLE = 1;
   localparam int CFG_STATIC = 2;
   localparam int CFG_DRVEN = 3;
   localparam int CFG_PP = 4;
   localparam int CFG_POL = 5;
   localparam int CFG_FAST = 6;
   localparam int CFG_FILT = 7;
   // mode fields
   localparam int MODE_LDO_DIS = 0;
   localparam int MODE_AUX_MON = 1;
   localparam int MODE_WAKE = 6;
   // ********************************
   // timing
   // ********************************
   localparam int CLK_MHZ = 50;
   localparam int SHORT_US = 160;
   localparam int OFF_US = 240;
   localparam int RETRY_US = 350;
   localparam int PERIOD_MS = 26;
   localparam int TICK_CYC = CLK_MHZ;
   localparam int SHORT_TICKS = SHORT_US;
   localparam int OFF_TICKS = OFF_US;
   localparam int RETRY_TICKS = RETRY_US;
   localparam int PERIOD_TICKS = PERIOD_MS * 1000;
   typedef enum logic [1:0] {
      FLT_IDLE = 2'b00,
      FLT_WAIT = 2'b01,
      FLT_OFF = 2'b10,
      FLT_RETRY = 2'b11
   } fault_state_t;
endpackage

// >>> hdl/line_xcvr_ctrl.sv
// Purpose: control logic of a master-side sensor line transceiver
// Assumes: analog comparators/monitors arrive asynchronously on pins
// Notes: wishbone registers, one clock, no interrupt block beyond irq pin
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module line_xcvr_ctrl
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic tx_drive_enable_pin,
   input wire logic transmit_comm_input,
   input wire logic transmit_level_input,
   input wire logic wake_pin_enable,
   input wire logic line_sense_high,
   input wire logic line_sense_low,
   input wire logic overcurrent,
   input wire logic aux_logic_input,
   input wire logic main_supply_ok,
   input wire logic logic_supply_ok,
   input wire logic level_supply_ok,
   input wire logic low_rail_ok,
   input wire logic temp_warn,
   input wire logic temp_cool,
   input wire logic temp_shutdown,
   output logic line_o,
   output logic line_oe_n,
   output logic push_pull_select,
   output logic open_drain_polarity_select,
   output logic fast_edge_select,
   output logic noise_filter_corner_select,
   output logic line_sink_enable,
   output logic aux_sink_enable,
   output logic low_rail_disable,
   output logic line_receive_output,
   output logic aux_level_output,
   output logic undervoltage_indicator_o,
   output logic undervoltage_indicator_oe_n,
   output logic interrupt_request_n
);
   // ********************************
   // input synchronisers
   // ********************************
   localparam int NSYNC = 14;
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync_q;
   assign async_in = {tx_drive_enable_pin, transmit_comm_input, transmit_level_input,
      wake_pin_enable, line_sense_high, line_sense_low, overcurrent, aux_logic_input,
      main_supply_ok, logic_supply_ok, level_supply_ok, low_rail_ok, temp_warn,
      temp_shutdown};
   // no reset: a cleared stage would look like a supply dip and latch false events
   always_ff @(posedge clk)
   begin
      sync1_q <= async_in;
      sync_q <= sync1_q;
   end
   logic tx_drive_enable_pin_s, txc_s, txq_s, wake_pin_enable_s, hi_s, lo_s, oc_s, di_s;
   logic vcc_ok, v5_ok, vl_ok, ldo_ok, warn_s, tsd_s;
   assign {tx_drive_enable_pin_s, txc_s, txq_s, wake_pin_enable_s, hi_s, lo_s, oc_s, di_s,
      vcc_ok, v5_ok, vl_ok, ldo_ok, warn_s, tsd_s} = sync_q;
   logic cool1_q, cool_q;
   always_ff @(posedge clk)
   begin
      cool1_q <= temp_cool;
      cool_q <= cool1_q;
   end

   // ********************************
   // registers
   // ********************************
   logic [7:0] cfg_q;
   logic [1:0] aux_cfg_q;
   logic [7:0] mode_q;
   logic line_fault_flag_q, main_supply_low_flag_q, hot_die_flag_q;
   logic line_fault_event_q, aux_supply_low_event_q, main_supply_low_event_q, hot_die_event_q;
   logic logic_ok;
   logic bus_req, status_read, wr_en;
   assign logic_ok = v5_ok & vl_ok;
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & logic_ok;
   assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
   assign status_read = bus_req & ~wb_we_i & (wb_adr_i[3:2] == line_xcvr_pkg::REG_STATUS);
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= bus_req;
   end
   // registers keep their values across supply dips; only sys_rst clears them
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cfg_q <= line_xcvr_pkg::LINE_CFG_RESET;
         aux_cfg_q <= line_xcvr_pkg::AUX_CFG_RESET;
         mode_q <= line_xcvr_pkg::MODE_RESET;
      end
      else if (wr_en)
      begin
         case (wb_adr_i[3:2])
            line_xcvr_pkg::REG_LINE_CFG: cfg_q <= wb_dat_i[7:0];
            line_xcvr_pkg::REG_AUX_CFG: aux_cfg_q <= wb_dat_i[1:0];
            line_xcvr_pkg::REG_MODE:
            begin
               mode_q[line_xcvr_pkg::MODE_LDO_DIS] <= wb_dat_i[line_xcvr_pkg::MODE_LDO_DIS];
               mode_q[line_xcvr_pkg::MODE_AUX_MON] <= wb_dat_i[line_xcvr_pkg::MODE_AUX_MON];
               mode_q[line_xcvr_pkg::MODE_WAKE] <= wb_dat_i[line_xcvr_pkg::MODE_WAKE];
            end
            default: cfg_q <= cfg_q;
         endcase
      end
   end
   logic [7:0] status_v, mode_v;
   assign status_v = {2'b00, di_s, lo_s, line_fault_event_q, aux_supply_low_event_q,
      main_supply_low_event_q, hot_die_event_q};
   assign mode_v = {1'b0, mode_q[line_xcvr_pkg::MODE_WAKE], 1'b0, line_fault_flag_q,
      main_supply_low_flag_q, hot_die_flag_q, mode_q[line_xcvr_pkg::MODE_AUX_MON],
      mode_q[line_xcvr_pkg::MODE_LDO_DIS]};
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wb_dat_o <= 32'h0000_0000;
      else if (bus_req && !wb_we_i)
      begin
         case (wb_adr_i[3:2])
            line_xcvr_pkg::REG_STATUS: wb_dat_o <= {24'h00_0000, status_v};
            line_xcvr_pkg::REG_LINE_CFG: wb_dat_o <= {24'h00_0000, cfg_q};
            line_xcvr_pkg::REG_AUX_CFG: wb_dat_o <= {30'h0000_0000, aux_cfg_q};
            line_xcvr_pkg::REG_MODE: wb_dat_o <= {24'h00_0000, mode_v};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ********************************
   // 1 us timebase
   // ********************************
   logic [5:0] pre_q;
   logic tick;
   assign tick = (pre_q == 6'(line_xcvr_pkg::TICK_CYC - 1));
   always_ff @(posedge clk)
   begin
      if (sys_rst || tick)
         pre_q <= 6'h00;
      else
         pre_q <= pre_q + 6'h01;
   end

   // ********************************
   // line fault and autoretry
   // ********************************
   line_xcvr_pkg::fault_state_t flt_q;
   logic [14:0] ft_q;
   logic [14:0] per_q;
   logic [7:0] oc_q;
   logic drv_req, drv_on, level_err, short_fault, fault_now, fault_off;
   logic od_mode;
   assign od_mode = ~cfg_q[line_xcvr_pkg::CFG_PP];
   assign level_err = od_mode & ~drv_req & ~hi_s & ~lo_s;
   // overcurrent held continuously; filter counts microseconds
   always_ff @(posedge clk)
   begin
      if (sys_rst || !oc_s)
         oc_q <= 8'h00;
      else if (tick && oc_q != 8'(line_xcvr_pkg::SHORT_TICKS))
         oc_q <= oc_q + 8'h01;
   end
   assign short_fault = (oc_q == 8'(line_xcvr_pkg::SHORT_TICKS));
   assign fault_now = short_fault | level_err;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         flt_q <= line_xcvr_pkg::FLT_IDLE;
         ft_q <= 15'h0000;
         per_q <= 15'h0000;
      end
      else
      begin
         if (tick)
            ft_q <= ft_q + 15'h0001;
         if (tick)
            per_q <= per_q + 15'h0001;
         case (flt_q)
            line_xcvr_pkg::FLT_IDLE:
               if (oc_s)
               begin
                  flt_q <= line_xcvr_pkg::FLT_WAIT;
                  ft_q <= 15'h0000;
               end
            line_xcvr_pkg::FLT_WAIT:
               if (!oc_s)
                  flt_q <= line_xcvr_pkg::FLT_IDLE;
               else if (ft_q == 15'(line_xcvr_pkg::OFF_TICKS))
               begin
                  flt_q <= line_xcvr_pkg::FLT_OFF;
                  per_q <= 15'h0000;
               end
            line_xcvr_pkg::FLT_OFF:
               if (per_q == 15'(line_xcvr_pkg::PERIOD_TICKS))
               begin
                  flt_q <= line_xcvr_pkg::FLT_RETRY;
                  ft_q <= 15'h0000;
               end
            line_xcvr_pkg::FLT_RETRY:
               if (ft_q == 15'(line_xcvr_pkg::RETRY_TICKS))
               begin
                  flt_q <= oc_s ? line_xcvr_pkg::FLT_OFF : line_xcvr_pkg::FLT_IDLE;
                  per_q <= 15'h0000;
               end
            default: flt_q <= line_xcvr_pkg::FLT_IDLE;
         endcase
      end
   end
   assign fault_off = (flt_q == line_xcvr_pkg::FLT_OFF);

   // ********************************
   // supply, temperature flags and events
   // ********************************
   logic all_ok, shutdown_q, irq_any;
   assign all_ok = vcc_ok & v5_ok & vl_ok & ldo_ok;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         line_fault_flag_q <= 1'b0;
         main_supply_low_flag_q <= 1'b0;
         hot_die_flag_q <= 1'b0;
         shutdown_q <= 1'b0;
      end
      else
      begin
         line_fault_flag_q <= fault_now | (line_fault_flag_q & (flt_q != line_xcvr_pkg::FLT_IDLE));
         main_supply_low_flag_q <= ~vcc_ok;
         if (warn_s)
            hot_die_flag_q <= 1'b1;
         else if (cool_q)
            hot_die_flag_q <= 1'b0;
         if (tsd_s)
            shutdown_q <= 1'b1;
         else if (cool_q)
            shutdown_q <= 1'b0;
      end
   end
   // set wins over the read clear; a held fault re-arms right after the read
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         line_fault_event_q <= 1'b0;
         aux_supply_low_event_q <= 1'b0;
         main_supply_low_event_q <= 1'b0;
         hot_die_event_q <= 1'b0;
      end
      else
      begin
         line_fault_event_q <= fault_now | line_fault_flag_q & status_read
            | (line_fault_event_q & ~status_read);
         aux_supply_low_event_q <= ~ldo_ok | (aux_supply_low_event_q & ~status_read);
         main_supply_low_event_q <= ~vcc_ok | (main_supply_low_event_q & ~status_read);
         hot_die_event_q <= (warn_s & ~hot_die_flag_q) | (hot_die_event_q & ~status_read);
      end
   end
   assign irq_any = line_fault_event_q | main_supply_low_event_q | hot_die_event_q
      | aux_supply_low_event_q;
   assign interrupt_request_n = ~(irq_any & logic_ok);

   // ********************************
   // driver, wake-up, receive path
   // ********************************
   logic wake_en, wake_act, wake_level_q, tx_and;
   assign tx_and = txc_s & txq_s;
   assign wake_en = wake_pin_enable_s | mode_q[line_xcvr_pkg::MODE_WAKE];
   assign wake_act = wake_en & ~tx_and;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wake_level_q <= 1'b0;
      else if (!wake_act)
         wake_level_q <= lo_s; // line low sensed: drive high
   end
   assign drv_req = tx_drive_enable_pin_s | cfg_q[line_xcvr_pkg::CFG_DRVEN] | wake_act;
   assign drv_on = drv_req & all_ok & ~fault_off & ~shutdown_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         line_o <= 1'b0;
         line_oe_n <= 1'b1;
      end
      else
      begin
         line_o <= wake_act ? wake_level_q : ~tx_and;
         // open-drain: only the active switch drives, the other level floats
         if (!drv_on)
            line_oe_n <= 1'b1;
         else if (cfg_q[line_xcvr_pkg::CFG_PP])
            line_oe_n <= 1'b0;
         else
            line_oe_n <= ~((wake_act ? wake_level_q : ~tx_and)
               == cfg_q[line_xcvr_pkg::CFG_POL]);
      end
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         push_pull_select <= 1'b0;
         open_drain_polarity_select <= 1'b0;
         fast_edge_select <= 1'b0;
         noise_filter_corner_select <= 1'b0;
         line_sink_enable <= 1'b0;
         aux_sink_enable <= 1'b0;
         low_rail_disable <= 1'b0;
         line_receive_output <= 1'b1;
         aux_level_output <= 1'b1;
         undervoltage_indicator_o <= 1'b0;
         undervoltage_indicator_oe_n <= 1'b1;
      end
      else
      begin
         push_pull_select <= cfg_q[line_xcvr_pkg::CFG_PP];
         open_drain_polarity_select <= cfg_q[line_xcvr_pkg::CFG_POL];
         fast_edge_select <= cfg_q[line_xcvr_pkg::CFG_FAST];
         noise_filter_corner_select <= cfg_q[line_xcvr_pkg::CFG_FILT];
         line_sink_enable <= cfg_q[line_xcvr_pkg::CFG_SINK] & ~drv_on & ~shutdown_q;
         aux_sink_enable <= aux_cfg_q[0] & ~shutdown_q;
         low_rail_disable <= mode_q[line_xcvr_pkg::MODE_LDO_DIS];
         line_receive_output <= cfg_q[line_xcvr_pkg::CFG_RECEIVE_OUTPUT_DISABLE] | lo_s;
         aux_level_output <= aux_cfg_q[1] | ~di_s;
         undervoltage_indicator_o <= 1'b1;
         // floats during logic-supply lockout; driven high on main or enabled rail fault
         undervoltage_indicator_oe_n <= ~(logic_ok & (~vcc_ok
            | (~ldo_ok & mode_q[line_xcvr_pkg::MODE_AUX_MON])));
      end
   end
endmodule

// >>> verif/line_xcvr_ctrl_asserts.sv
// Purpose: port assertions for line_xcvr_ctrl
// Assumes: inputs act after two sync flops and a 1us tick
// Notes: windows leave slack for that latency
`timescale 1ns/1ps
module line_xcvr_ctrl_asserts
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic transmit_comm_input,
   input wire logic transmit_level_input,
   input wire logic wake_pin_enable,
   input wire logic line_sense_low,
   input wire logic overcurrent,
   input wire logic main_supply_ok,
   input wire logic logic_supply_ok,
   input wire logic level_supply_ok,
   input wire logic low_rail_ok,
   input wire logic temp_shutdown,
   input wire logic line_o,
   input wire logic line_oe_n,
   input wire logic push_pull_select,
   input wire logic line_sink_enable,
   input wire logic aux_sink_enable,
   input wire logic line_receive_output,
   input wire logic undervoltage_indicator_oe_n,
   input wire logic interrupt_request_n
);
   // ****************
   // overcurrent run length
   // ****************
   localparam logic [15:0] IRQ_AT = 16'h206c;
   localparam logic [15:0] OFF_AT = 16'h300c;
   localparam logic [15:0] OFF_END = 16'h4e20;
   logic [15:0] oc_cnt_q;
   logic [15:0] oc_cnt_d;
   logic rails_ok;
   // saturates so a long short never wraps back into the window
   assign oc_cnt_d = !overcurrent ? 16'h0000 : (&oc_cnt_q ? oc_cnt_q : oc_cnt_q + 16'h0001);
   assign rails_ok = logic_supply_ok && level_supply_ok;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         oc_cnt_q <= 16'h0000;
      else
         oc_cnt_q <= oc_cnt_d;
   end
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_ack_refused: assert property ((!logic_supply_ok)[*5] |-> !wb_ack_o)
      else $error("ack in logic undervoltage");
   a_rx_line_low: assert property (line_sense_low[*5] |-> line_receive_output)
      else $error("rx low on low line");
   a_main_low: assert property ((!main_supply_ok && rails_ok)[*5] |->
      !interrupt_request_n && !undervoltage_indicator_oe_n && line_oe_n)
      else $error("main low not reported");
   a_uv_idle: assert property ((main_supply_ok && rails_ok && low_rail_ok)[*5] |->
      undervoltage_indicator_oe_n)
      else $error("indicator on, supplies good");
   a_hot_off: assert property (temp_shutdown[*5] |->
      line_oe_n && !line_sink_enable && !aux_sink_enable)
      else $error("drive or sink in shutdown");
   a_fault_irq: assert property (oc_cnt_q == IRQ_AT && !line_oe_n && rails_ok |->
      !interrupt_request_n)
      else $error("short not flagged");
   a_fault_off: assert property (oc_cnt_q >= OFF_AT && oc_cnt_q <= OFF_END |-> line_oe_n)
      else $error("driver on after short");
   a_line_nand: assert property ((transmit_comm_input && transmit_level_input)[*5]
      ##0 (push_pull_select && !line_oe_n) |-> !line_o)
      else $error("push-pull level wrong");
   c_read_ack: cover property (wb_ack_o && wb_cyc_i);
   c_short_off: cover property (oc_cnt_q == OFF_AT && line_oe_n);
   c_wake_drive: cover property (wake_pin_enable && !line_oe_n);
   c_irq: cover property (!interrupt_request_n);
endmodule

// >>> verif/host_pins_model.sv
// Purpose: host pin model for transmit, enable and wake pins
// Assumes: wake pulse length is given in clk cycles
// Notes: soft wake leaves the pin low; the bench sets the mode bit
`timescale 1ns/1ps
module host_pins_model
#(
   parameter int WAKE_CYC = 4000
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tx_bit,
   input wire logic tx_en,
   input wire logic wake_go,
   input wire logic wake_soft,
   output logic tx_drive_enable_pin,
   output logic transmit_comm_input,
   output logic transmit_level_input,
   output logic wake_pin_enable,
   output logic wake_busy
);
   logic [1:0] phase_q;
   logic [15:0] cnt_q;
   logic [15:0] lim_w;
   // phases: idle, enable up, pulse low, settle before enable drops
   assign lim_w = (phase_q == 2'h2) ? 16'(WAKE_CYC) : 16'h000a;
   assign wake_busy = (phase_q != 2'h0);
   assign transmit_level_input = 1'b1;
   assign tx_drive_enable_pin = tx_en && (phase_q == 2'h0);
   assign transmit_comm_input = (phase_q == 2'h2) ? 1'b0 : (wake_busy || tx_bit);
   assign wake_pin_enable = !wake_soft && wake_busy;
   always_ff @(posedge clk)
   begin
      if (sys_rst || (phase_q == 2'h0))
      begin
         phase_q <= (!sys_rst && wake_go) ? 2'h1 : 2'h0;
         cnt_q <= 16'h0000;
      end
      else if (cnt_q == lim_w)
      begin
         phase_q <= phase_q + 2'h1;
         cnt_q <= 16'h0000;
      end
      else
         cnt_q <= cnt_q + 16'h0001;
   end
endmodule

// >>> verif/line_xcvr_ctrl_tb.sv
// Purpose: self-checking bench for line_xcvr_ctrl
// Assumes: ack within 20 cycles while logic supplies are good
// Notes: 26ms retry period not reached
`timescale 1ns/1ps
module line_xcvr_ctrl_tb;
   localparam int LIMIT = 60000;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
   logic tx_drive_enable_pin, transmit_comm_input, transmit_level_input, wake_pin_enable;
   logic line_sense_high = 1'b1, line_sense_low = 1'b0, overcurrent = 1'b0;
   logic aux_logic_input = 1'b0, main_supply_ok = 1'b1, logic_supply_ok = 1'b1;
   logic level_supply_ok = 1'b1, low_rail_ok = 1'b1, temp_warn = 1'b0;
   logic temp_cool = 1'b1, temp_shutdown = 1'b0;
   logic line_o, line_oe_n, push_pull_select, open_drain_polarity_select, fast_edge_select;
   logic noise_filter_corner_select, line_sink_enable, aux_sink_enable, low_rail_disable;
   logic line_receive_output, aux_level_output, undervoltage_indicator_o;
   logic undervoltage_indicator_oe_n, interrupt_request_n;
   logic tx_bit = 1'b1, tx_en = 1'b0, wake_go = 1'b0, wake_soft = 1'b0, wake_busy;
   logic [7:0] q, v;
   logic got;
   int errors = 0, comparisons = 0, cyc_count = 0;
   integer seed = 32'hc68d_3ac2;
   line_xcvr_ctrl line_xcvr_ctrl_i (.*);
   host_pins_model host_pins_model_i (.*);
   always #10 clk = ~clk;
   // ****************
   // bus and check tasks
   // ****************
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string s);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, s, g, e);
      end
   endtask
   // request held until ack is sampled or 20 cycles pass; upper data bits are junk on purpose
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'($random(seed)), d};
      n = 0;
      got = 1'b0;
      while (n < 20 && !got)
      begin
         @(posedge clk);
         got = (wb_ack_o === 1'b1);
         n++;
      end
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      wb(1'b1, a, d, 4'hf);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
      wb(1'b0, a, 8'h00, 4'hf);
      chk(q & m, e, s);
   endtask
   function automatic logic [7:0] cfg_pins(input logic [7:0] c);
      return {3'h0, c[0], c[4], c[5], c[6], c[7]};
   endfunction
   task automatic print_verdict;
      $display("counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc_count++;
      if (cyc_count == LIMIT)
      begin
         errors++;
         print_verdict();
      end
   end
   // ****************
   // scenarios
   // ****************
   initial
   begin
      wt(4);
      sys_rst <= 1'b0;
      rdc(4'h0, 8'hcf, 8'h00, "status");
      rdc(4'hc, 8'hff, 8'h00, "mode");
      for (int i = 0; i < 4; i++)
      begin
         v = 8'($random(seed)) & 8'hf7;
         wr(4'h4, v);
         rdc(4'h4, 8'hff, v, "cfg");
         chk({3'h0, line_sink_enable, push_pull_select, open_drain_polarity_select,
            fast_edge_select, noise_filter_corner_select},
            cfg_pins(v), "pins");
      end
      wb(1'b1, 4'h4, 8'hff, 4'he);
      rdc(4'h4, 8'hff, v, "lane");
      $display("test config done");
      wr(4'h4, 8'h02);
      line_sense_low <= 1'b1;
      line_sense_high <= 1'b0;
      aux_logic_input <= 1'b1;
      wt(5);
      chk({6'h00, line_receive_output, aux_level_output}, 8'h02, "rx off");
      rdc(4'h0, 8'h30, 8'h30, "level");
      line_sense_low <= 1'b0;
      line_sense_high <= 1'b1;
      aux_logic_input <= 1'b0;
      wr(4'h4, 8'h00);
      wt(5);
      chk({6'h00, line_receive_output, aux_level_output}, 8'h01, "rx on");
      $display("test receive done");
      wr(4'h4, 8'h18);
      for (int i = 0; i < 6; i++)
      begin
         v = 8'($random(seed));
         tx_bit <= v[0];
         wt(5);
         chk({6'h00, line_oe_n, line_o}, {7'h00, !v[0]}, "drive");
      end
      tx_bit <= 1'b1;
      wr(4'h4, 8'h10);
      tx_en <= 1'b1;
      wt(5);
      chk({7'h00, line_oe_n}, 8'h00, "pin en");
      main_supply_ok <= 1'b0;
      wt(6);
      chk({5'h00, interrupt_request_n, undervoltage_indicator_oe_n, line_oe_n}, 8'h01, "main");
      main_supply_ok <= 1'b1;
      wt(6);
      chk({5'h00, interrupt_request_n, undervoltage_indicator_oe_n, line_oe_n}, 8'h02, "back");
      rdc(4'h0, 8'h0f, 8'h02, "main ev");
      wt(2);
      chk({7'h00, interrupt_request_n}, 8'h01, "irq clr");
      tx_en <= 1'b0;
      low_rail_ok <= 1'b0;
      wt(6);
      chk({7'h00, undervoltage_indicator_oe_n}, 8'h01, "rail quiet");
      wr(4'hc, 8'h03);
      wt(4);
      chk({6'h00, undervoltage_indicator_oe_n, low_rail_disable}, 8'h01, "rail mon");
      low_rail_ok <= 1'b1;
      wt(6);
      rdc(4'h0, 8'h04, 8'h04, "rail ev");
      wr(4'hc, 8'h00);
      logic_supply_ok <= 1'b0;
      wt(4);
      wb(1'b0, 4'h4, 8'h00, 4'hf);
      chk({7'h00, got}, 8'h00, "refused");
      logic_supply_ok <= 1'b1;
      wt(4);
      rdc(4'h4, 8'hff, 8'h10, "kept");
      $display("test supply done");
      wr(4'h4, 8'h00);
      line_sense_high <= 1'b0;
      wt(6);
      rdc(4'hc, 8'h10, 8'h10, "od flag");
      rdc(4'h0, 8'h08, 8'h08, "od ev");
      chk({7'h00, interrupt_request_n}, 8'h00, "od irq");
      line_sense_high <= 1'b1;
      wt(6);
      rdc(4'h0, 8'h08, 8'h08, "re-set");
      rdc(4'h0, 8'h08, 8'h00, "cleared");
      $display("test open drain done");
      wr(4'h4, 8'h10);
      wr(4'h8, 8'h01);
      tx_en <= 1'b1;
      temp_warn <= 1'b1;
      temp_cool <= 1'b0;
      wt(6);
      rdc(4'h0, 8'h0f, 8'h01, "hot ev");
      rdc(4'hc, 8'h04, 8'h04, "hot flag");
      chk({7'h00, interrupt_request_n}, 8'h01, "hot read");
      temp_shutdown <= 1'b1;
      wt(6);
      chk({6'h00, line_oe_n, aux_sink_enable}, 8'h02, "shut");
      temp_shutdown <= 1'b0;
      temp_warn <= 1'b0;
      temp_cool <= 1'b1;
      wt(6);
      chk({6'h00, line_oe_n, aux_sink_enable}, 8'h01, "restore");
      rdc(4'hc, 8'h04, 8'h00, "cool");
      tx_en <= 1'b0;
      wr(4'h8, 8'h00);
      $display("test thermal done");
      line_sense_low <= 1'b1;
      line_sense_high <= 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         wake_soft <= (k == 1);
         wr(4'hc, (k == 1) ? 8'h40 : 8'h00);
         wake_go <= 1'b1;
         wt(1);
         wake_go <= 1'b0;
         wt(2000);
         chk({6'h00, line_oe_n, line_o}, 8'h01, "wake");
         for (int n = 0; n < 5000 && wake_busy; n++)
            @(posedge clk);
         wt(6);
         chk({7'h00, line_oe_n}, 8'h01, "wake off");
      end
      wr(4'hc, 8'h00);
      line_sense_low <= 1'b0;
      line_sense_high <= 1'b1;
      $display("test wake done");
      wr(4'h4, 8'h18);
      overcurrent <= 1'b1;
      wt(9000);
      chk({6'h00, interrupt_request_n, line_oe_n}, 8'h00, "short");
      wt(3500);
      chk({7'h00, line_oe_n}, 8'h01, "short off");
      rdc(4'h0, 8'h08, 8'h08, "short ev");
      overcurrent <= 1'b0;
      sys_rst <= 1'b1;
      wt(2);
      sys_rst <= 1'b0;
      rdc(4'h4, 8'hff, 8'h00, "rst cfg");
      $display("test short done");
      print_verdict();
   end
endmodule
bind line_xcvr_ctrl line_xcvr_ctrl_asserts line_xcvr_ctrl_asserts_i (.*);
